//--- rtl/serial_port_clock_select.v
// per-port clock generation, selection and serial data path
`timescale 1ns/100ps
`default_nettype none
`include "clock_select_map.vh"

module serial_port_clock_select #(
  parameter REF_TICKS = 16'h1000,
  parameter FOUR_WIRE_WORD = 32'h000FA000,
  parameter FIFO_ADDR_BITS = 4
) (
  input wire clock,
  input wire srst,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // reference and serial pins
  input wire refPortIn,
  input wire refExtIn,
  input wire terminalTimingIn,
  input wire txDataIn,
  output wire sendTimingOut,
  output wire receiveTimingOut,
  output reg rxDataOut,
  // network-bound packet stream
  output reg [7:0] pktData,
  output reg pktValid,
  output reg pktFirst,
  output reg pktLast,
  // interface-bound payload stream
  input wire [7:0] ifByte,
  input wire ifByteValid,
  input wire ifByteHeader,
  output wire ifByteReady
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[1:0] == 2'h0) && (addr <= `REG_STATUS);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  // standard modes force the selector sources
  function [1:0] modeSel;
    input [2:0] mode;
    input [2:0] idx;
    input [9:0] custom;
    begin
      case (mode)
        `MODE_CFG_INT: modeSel = `SRC_SYNTH;
        `MODE_CFG_TT: modeSel = (idx == 3'h2) ? `SRC_TT : `SRC_SYNTH;
        `MODE_ALL_TT: modeSel = `SRC_TT;
        `MODE_FOUR_WIRE: modeSel = `SRC_SYNTH;
        `MODE_CUSTOM: modeSel = custom[idx*2 +: 2];
        default: modeSel = `SRC_OFF;
      endcase
    end
  endfunction

  // ----------------------------------------
  // registers and bus slave
  // ----------------------------------------
  reg [2:0] clkMode;
  reg refSel;
  reg [31:0] synthWord;
  reg divSrc;
  reg [14:0] divValue;
  reg [9:0] clkSelCfg;
  reg [10:0] pktSize;
  reg overflowFlag;
  reg underrunFlag;
  reg awHeld;
  reg [7:0] awAddr;
  reg wHeld;
  reg [31:0] wData;
  reg [3:0] wStrb;
  wire pllLocked;
  wire divBad;
  wire synBad;
  wire [9:0] curSelFlat;
  wire doWrite;
  wire [31:0] statusWord;
  reg [31:0] next_rdata;
  wire overflowEvent;
  wire underrunEvent;
  // held write data merged into each register under the byte strobes
  wire [31:0] ctrlNew = merge({27'h0, refSel, 1'b0, clkMode}, wData, wStrb);
  wire [31:0] divNew = merge({15'h0, divSrc, 1'b0, divValue}, wData, wStrb);
  wire [31:0] selNew = merge({22'h0, clkSelCfg}, wData, wStrb);
  wire [31:0] pktNew = merge({21'h0, pktSize}, wData, wStrb);

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign statusWord = {14'h0000, curSelFlat, 3'h0, underrunFlag, overflowFlag, synBad, divBad, pllLocked};

  // write channel capture, register update and response
  always @(posedge clock) begin
    if (srst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      clkMode <= `RST_MODE;
      refSel <= 1'b0;
      synthWord <= `RST_SYNTH_WORD;
      divSrc <= 1'b0;
      divValue <= `RST_DIV_VALUE;
      clkSelCfg <= `RST_CLK_SEL;
      pktSize <= `RST_PKT_SIZE;
      overflowFlag <= 1'b0;
      underrunFlag <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr) ? 2'h0 : 2'h2;
        case (awAddr)
          `REG_CTRL: begin
            refSel <= ctrlNew[`CTRL_REF_SEL_BIT];
            clkMode <= ctrlNew[2:0];
          end
          `REG_SYNTH_WORD: synthWord <= merge(synthWord, wData, wStrb);
          `REG_DIV_CTRL: begin
            divSrc <= divNew[`DIV_SRC_BIT];
            divValue <= divNew[14:0];
          end
          `REG_CLK_SEL: clkSelCfg <= selNew[9:0];
          `REG_PKT_SIZE: pktSize <= pktNew[10:0];
          default: ;
        endcase
      end
      // sticky flags: write one to clear, a new event wins
      if (doWrite && awAddr == `REG_STATUS && wStrb[0]) begin
        if (wData[`STAT_OVERFLOW_BIT]) overflowFlag <= 1'b0;
        if (wData[`STAT_UNDERRUN_BIT]) underrunFlag <= 1'b0;
      end
      if (overflowEvent) overflowFlag <= 1'b1;
      if (underrunEvent) underrunFlag <= 1'b1;
    end
  end

  // read data select
  always @* begin
    case (s_axi_araddr)
      `REG_CTRL: next_rdata = {27'h0, refSel, 1'b0, clkMode};
      `REG_SYNTH_WORD: next_rdata = synthWord;
      `REG_DIV_CTRL: next_rdata = {15'h0, divSrc, 1'b0, divValue};
      `REG_CLK_SEL: next_rdata = {22'h0, clkSelCfg};
      `REG_PKT_SIZE: next_rdata = {21'h0, pktSize};
      `REG_STATUS: next_rdata = statusWord;
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read response, one cycle after the address
  always @(posedge clock) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [3:0] pinMeta;
  reg [3:0] pinSync;
  reg [2:0] pinLast;

  // two flops on every asynchronous pin
  always @(posedge clock) begin
    if (srst) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
      pinLast <= 3'h0;
    end else begin
      pinMeta <= {txDataIn, terminalTimingIn, refExtIn, refPortIn};
      pinSync <= pinMeta;
      pinLast <= pinSync[2:0];
    end
  end

  wire refLevel = refSel ? pinSync[1] : pinSync[0];
  wire refLast = refSel ? pinLast[1] : pinLast[0];
  wire refRise = refLevel && !refLast;
  wire ttLevel = pinSync[2];
  wire ttEvent = pinSync[2] ^ pinLast[2];

  // ----------------------------------------
  // node oscillator and frequency lock
  // ----------------------------------------
  reg [16:0] oscAcc;
  reg oscTick;
  reg signed [7:0] oscTrim;
  reg [15:0] refCount;
  reg lockFlag;
  wire [17:0] oscSum = {1'b0, oscAcc} + {1'b0, `OSC_STEP} + {{10{oscTrim[7]}}, oscTrim};

  // 32.768 MHz tick from the 125 MHz clock, trimmed by the lock loop
  always @(posedge clock) begin
    if (srst) begin
      oscAcc <= 17'h00000;
      oscTick <= 1'b0;
    end else if (oscSum >= {1'b0, `OSC_MOD}) begin
      oscAcc <= oscSum[16:0] - `OSC_MOD;
      oscTick <= 1'b1;
    end else begin
      oscAcc <= oscSum[16:0];
      oscTick <= 1'b0;
    end
  end

  // count oscillator ticks per reference period and nudge the trim
  always @(posedge clock) begin
    if (srst) begin
      refCount <= 16'h0000;
      oscTrim <= 8'sh00;
      lockFlag <= 1'b0;
    end else if (refRise) begin
      refCount <= 16'h0000;
      lockFlag <= (refCount == REF_TICKS);
      if (refCount > REF_TICKS && oscTrim != -8'sd128) begin
        oscTrim <= oscTrim - 8'sd1;
      end else if (refCount < REF_TICKS && oscTrim != 8'sd127) begin
        oscTrim <= oscTrim + 8'sd1;
      end
    end else if (oscTick && refCount != 16'hFFFF) begin
      refCount <= refCount + 16'h0001;
    end
  end
  assign pllLocked = lockFlag;

  // ----------------------------------------
  // frequency synthesizer
  // ----------------------------------------
  reg [32:0] synAcc;
  reg synLevel;
  reg synEvent;
  wire [31:0] effWord = (clkMode == `MODE_FOUR_WIRE) ? FOUR_WIRE_WORD : synthWord;
  assign synBad = (effWord < `SYN_WORD_MIN) || (effWord > `SYN_WORD_MAX);
  wire [33:0] synSum = {1'b0, synAcc} + {1'b0, effWord, 1'b0};

  // phase accumulator clocked by oscillator ticks, two edges per period
  always @(posedge clock) begin
    if (srst) begin
      synAcc <= 33'h000000000;
      synLevel <= 1'b0;
      synEvent <= 1'b0;
    end else begin
      synEvent <= 1'b0;
      if (oscTick && !synBad) begin
        if (synSum >= {1'b0, `SYN_MOD}) begin
          synAcc <= synSum[32:0] - `SYN_MOD;
          synLevel <= !synLevel;
          synEvent <= 1'b1;
        end else begin
          synAcc <= synSum[32:0];
        end
      end
    end
  end

  // ----------------------------------------
  // even divider
  // ----------------------------------------
  reg [13:0] divCount;
  reg divLevel;
  reg divEvent;
  assign divBad = divValue[0] || (divValue < `DIV_MIN) || (divValue > `DIV_MAX);
  wire divIn = divSrc ? (synEvent && synLevel) : oscTick;

  // toggle after every half of the divisor in input periods
  always @(posedge clock) begin
    if (srst) begin
      divCount <= 14'h0000;
      divLevel <= 1'b0;
      divEvent <= 1'b0;
    end else begin
      divEvent <= 1'b0;
      if (divBad) begin
        divCount <= 14'h0000;
      end else if (divIn) begin
        if (divCount >= divValue[14:1] - 14'h0001) begin
          divCount <= 14'h0000;
          divLevel <= !divLevel;
          divEvent <= 1'b1;
        end else begin
          divCount <= divCount + 14'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // five glitch-free clock selectors
  // ----------------------------------------
  wire [3:0] srcLevel = {1'b0, ttLevel, divLevel, synLevel};
  wire [3:0] srcEvent = {1'b0, ttEvent, divEvent, synEvent};
  wire [4:0] selLevel;
  wire [4:0] selRise;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : sel
      reg [1:0] cur;
      reg level;
      reg rise;
      wire [1:0] want = modeSel(clkMode, g, clkSelCfg);

      // switch only while the output is low, then follow the new source
      always @(posedge clock) begin
        if (srst) begin
          cur <= `SRC_OFF;
          level <= 1'b0;
          rise <= 1'b0;
        end else if (want != cur && !level) begin
          cur <= want;
          rise <= 1'b0;
        end else if (srcEvent[cur]) begin
          level <= srcLevel[cur];
          rise <= srcLevel[cur] && !level;
        end else begin
          rise <= 1'b0;
        end
      end
      assign selLevel[g] = level;
      assign selRise[g] = rise;
      assign curSelFlat[g*2 +: 2] = cur;
    end
  endgenerate

  assign sendTimingOut = selLevel[0];
  assign receiveTimingOut = selLevel[3];

  // ----------------------------------------
  // network-bound path and Rx FIFO
  // ----------------------------------------
  localparam DEPTH = 1 << FIFO_ADDR_BITS;
  reg [7:0] txShift;
  reg [2:0] txBits;
  reg [FIFO_ADDR_BITS-1:0] wrPtr;
  reg [FIFO_ADDR_BITS-1:0] rdPtr;
  reg [FIFO_ADDR_BITS:0] fill;
  reg readPending;
  reg [10:0] pktCount;
  wire [7:0] fifoOut;
  wire byteDone = selRise[2] && (txBits == 3'h7);
  wire fifoWrite = byteDone && (fill != DEPTH);
  wire fifoRead = selRise[1] && (fill != 0);
  wire [10:0] pktLimit = (pktSize < `PKT_MIN) ? `PKT_MIN : (pktSize > `PKT_MAX) ? `PKT_MAX : pktSize;
  assign overflowEvent = byteDone && (fill == DEPTH);

  // sample DTE data on the serial controller clock, terminal timing when so selected
  always @(posedge clock) begin
    if (srst) begin
      txShift <= 8'h00;
      txBits <= 3'h0;
    end else if (selRise[2]) begin
      txShift <= {pinSync[3], txShift[7:1]};
      txBits <= txBits + 3'h1;
    end
  end

  // fifo pointers: written on the sampling clock, drained on the fifo clock
  always @(posedge clock) begin
    if (srst) begin
      wrPtr <= {FIFO_ADDR_BITS{1'b0}};
      rdPtr <= {FIFO_ADDR_BITS{1'b0}};
      fill <= {(FIFO_ADDR_BITS+1){1'b0}};
    end else begin
      if (fifoWrite) wrPtr <= wrPtr + 1'b1;
      if (fifoRead) rdPtr <= rdPtr + 1'b1;
      fill <= fill + {{FIFO_ADDR_BITS{1'b0}}, fifoWrite} - {{FIFO_ADDR_BITS{1'b0}}, fifoRead};
    end
  end

  byte_store #(
    .WIDTH(8),
    .ADDR_BITS(FIFO_ADDR_BITS)
  ) rxFifo (
    .clock(clock),
    .writeEn(fifoWrite),
    .writeAddr(wrPtr),
    .writeData({pinSync[3], txShift[7:1]}),
    .readEn(fifoRead),
    .readAddr(rdPtr),
    .readData(fifoOut)
  );

  // cut drained bytes into packets of the configured size clamped to PKT_MIN..PKT_MAX
  always @(posedge clock) begin
    if (srst) begin
      readPending <= 1'b0;
      pktCount <= 11'h000;
      pktData <= 8'h00;
      pktValid <= 1'b0;
      pktFirst <= 1'b0;
      pktLast <= 1'b0;
    end else begin
      readPending <= fifoRead;
      pktValid <= readPending;
      if (readPending) begin
        pktData <= fifoOut;
        pktFirst <= (pktCount == 11'h000);
        pktLast <= (pktCount >= pktLimit - 11'h001);
        pktCount <= (pktCount >= pktLimit - 11'h001) ? 11'h000 : pktCount + 11'h001;
      end
    end
  end

  // ----------------------------------------
  // interface-bound serial output
  // ----------------------------------------
  reg [7:0] holdByte;
  reg holdFull;
  reg [7:0] rxShift;
  reg [2:0] rxBits;
  assign ifByteReady = !holdFull;
  wire loadNow = selRise[4] && (rxBits == 3'h0);
  assign underrunEvent = loadNow && !holdFull;

  // one-byte holding stage, header bytes are dropped
  always @(posedge clock) begin
    if (srst) begin
      holdByte <= 8'h00;
      holdFull <= 1'b0;
    end else if (ifByteValid && !holdFull && !ifByteHeader) begin
      holdByte <= ifByte;
      holdFull <= 1'b1;
    end else if (loadNow) begin
      holdFull <= 1'b0;
    end
  end

  // constant bit stream, idle ones when no payload waits
  always @(posedge clock) begin
    if (srst) begin
      rxShift <= 8'hFF;
      rxBits <= 3'h0;
      rxDataOut <= 1'b1;
    end else if (selRise[4]) begin
      rxBits <= rxBits + 3'h1;
      if (rxBits == 3'h0) begin
        rxShift <= holdFull ? {1'b1, holdByte[7:1]} : 8'hFF;
        rxDataOut <= holdFull ? holdByte[0] : 1'b1;
      end else begin
        rxShift <= {1'b1, rxShift[7:1]};
        rxDataOut <= rxShift[0];
      end
    end
  end

endmodule // serial_port_clock_select

`default_nettype wire

//--- rtl/clock_select_map.vh
// constants for the serial port clock selection block
`ifndef CLOCK_SELECT_MAP_VH
`define CLOCK_SELECT_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_SYNTH_WORD 8'h04
`define REG_DIV_CTRL 8'h08
`define REG_CLK_SEL 8'h0C
`define REG_PKT_SIZE 8'h10
`define REG_STATUS 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_REF_SEL_BIT 4
`define DIV_SRC_BIT 16
`define STAT_LOCKED_BIT 0
`define STAT_DIV_BAD_BIT 1
`define STAT_SYN_BAD_BIT 2
`define STAT_OVERFLOW_BIT 3
`define STAT_UNDERRUN_BIT 4
`define STAT_SEL_LSB 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MODE 3'h0
`define RST_SYNTH_WORD 32'h07D00000
`define RST_DIV_VALUE 15'h4000
`define RST_CLK_SEL 10'h000
`define RST_PKT_SIZE 11'h400

// ----------------------------------------
// clock modes and selector sources
// ----------------------------------------
`define MODE_CFG_INT 3'h0
`define MODE_CFG_TT 3'h1
`define MODE_ALL_TT 3'h2
`define MODE_FOUR_WIRE 3'h3
`define MODE_CUSTOM 3'h4
`define SRC_SYNTH 2'h0
`define SRC_DIV 2'h1
`define SRC_TT 2'h2
`define SRC_OFF 2'h3

// ----------------------------------------
// timing and rate figures
// ----------------------------------------
`define CLOCK_KHZ 125000
`define OSC_KHZ 32768
`define OSC_MOD 17'h1E848
`define OSC_STEP 17'h08000
`define SYN_MOD 33'h0FA000000
`define SYN_WORD_MIN 32'h00000080
`define SYN_WORD_MAX 32'h5DC00000
`define DIV_MIN 15'h0002
`define DIV_MAX 15'h4000
`define PKT_MIN 11'h020
`define PKT_MAX 11'h5B0

`endif

//--- rtl/byte_store.v
// dual-port byte memory with registered read data
`timescale 1ns/100ps
`default_nettype none

module byte_store #(
  parameter WIDTH = 8,
  parameter ADDR_BITS = 4
) (
  input wire clock,
  input wire writeEn,
  input wire [ADDR_BITS-1:0] writeAddr,
  input wire [WIDTH-1:0] writeData,
  input wire readEn,
  input wire [ADDR_BITS-1:0] readAddr,
  output reg [WIDTH-1:0] readData
);

  reg [WIDTH-1:0] store [0:(1<<ADDR_BITS)-1];

  // write port and registered read port
  always @(posedge clock) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
    if (readEn) begin
      readData <= store[readAddr];
    end
  end

endmodule // byte_store

`default_nettype wire

//--- dv/dte_partner.sv
// attached serial equipment: loops send timing back and sends data
`timescale 1ns/100ps
`default_nettype none
module dte_partner (
  input wire logic clock,
  input wire logic sendTiming,
  input wire logic [7:0] txByte,
  output logic terminalTiming,
  output logic txData
);
  logic [3:0] skew = 4'h0;
  logic [2:0] bitIdx = 3'h0;
  // cable delay on the returned timing clock
  always @(posedge clock) begin
    skew <= {skew[2:0], sendTiming};
  end
  assign terminalTiming = skew[3];
  initial txData = 1'b1;
  // data moves on the falling edge, lsb first
  always @(negedge terminalTiming) begin
    txData <= txByte[bitIdx];
    bitIdx <= bitIdx + 3'h1;
  end
endmodule // dte_partner
`default_nettype wire

//--- dv/serial_port_clock_select_assertions.sv
// port checker for the clock selection block
`timescale 1ns/100ps
`default_nettype none
module serial_port_clock_select_assertions (
  input wire logic clock,
  input wire logic srst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sendTimingOut,
  input wire logic receiveTimingOut,
  input wire logic rxDataOut,
  input wire logic pktValid,
  input wire logic pktFirst,
  input wire logic pktLast
);
  default clocking cb @(posedge clock); endclocking
  chk_reset_idle: assert property (srst |=> rxDataOut && !pktValid && !sendTimingOut && !receiveTimingOut)
    else $error("outputs not idle after reset");
  chk_b_stands: assert property (disable iff (srst) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_stands: assert property (disable iff (srst) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_latency: assert property (disable iff (srst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_refused: assert property (disable iff (srst) s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_w_refused: assert property (disable iff (srst) s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_pkt_pulse: assert property (disable iff (srst) pktValid |=> !pktValid)
    else $error("packet strobe too long");
  chk_pkt_marks: assert property (disable iff (srst) pktValid && pktLast |-> !pktFirst)
    else $error("packet shorter than two bytes");
  chk_st_no_runt: assert property (disable iff (srst) $rose(sendTimingOut) |-> sendTimingOut [*3])
    else $error("runt on send timing");
  chk_rt_no_runt: assert property (disable iff (srst) $rose(receiveTimingOut) |=> receiveTimingOut [*2])
    else $error("runt on receive timing");
endmodule // serial_port_clock_select_assertions
bind serial_port_clock_select serial_port_clock_select_assertions u_chk (.clock, .srst, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .sendTimingOut, .receiveTimingOut, .rxDataOut, .pktValid, .pktFirst, .pktLast);
`default_nettype wire

//--- dv/tb_serial_port_clock_select.sv
// self-checking bench for the clock selection block
`timescale 1ns/100ps
`default_nettype none
`include "clock_select_map.vh"
module tb_serial_port_clock_select;
  logic clock, srst, awValid, wValid, bReady, arValid, rReady, ifValid, ifHdr, refIn;
  logic [3:0] wStrb;
  logic [7:0] awAddr, arAddr, ifData, txByte, pData;
  logic [31:0] wData, rData, rv;
  logic [1:0] bResp, rResp, rr;
  logic awReady, wReady, bValid, arReady, rValid, ttIn, txIn, stOut, rtOut, rxOut, pValid, pFirst, pLast, ifReady;
  int failures, tests_run, cyc, c;
  serial_port_clock_select #(.REF_TICKS(16'h1000), .FOUR_WIRE_WORD(32'h0FA00000), .FIFO_ADDR_BITS(4)) u_dut (
    .clock(clock), .srst(srst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .refPortIn(refIn), .refExtIn(1'b0),
    .terminalTimingIn(ttIn), .txDataIn(txIn), .sendTimingOut(stOut), .receiveTimingOut(rtOut),
    .rxDataOut(rxOut), .pktData(pData), .pktValid(pValid), .pktFirst(pFirst), .pktLast(pLast),
    .ifByte(ifData), .ifByteValid(ifValid), .ifByteHeader(ifHdr), .ifByteReady(ifReady));
  dte_partner u_dte (.clock(clock), .sendTiming(stOut), .txByte(txByte), .terminalTiming(ttIn), .txData(txIn));
  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic near(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  // ----------------------------------------
  // register bus master
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    @(posedge clock);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clock);
      ta = awValid && awReady;
      tw = wValid && wReady;
      done = bValid;
      @(posedge clock);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
      if (done) bReady <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, done;
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge clock);
      ta = arValid && arReady;
      done = rValid;
      d = rData;
      r = rResp;
      @(posedge clock);
      if (ta) arValid <= 1'b0;
      if (done) rReady <= 1'b0;
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, rv, rr);
    check(rv & m, e);
  endtask
  // cycles spanned by eight periods (nine rising edges) of one timing output
  task automatic per(input int s, output int n);
    int k, t0;
    logic p, v;
    p = 1'b1;
    k = 0;
    n = 0;
    t0 = 0;
    repeat (100) @(posedge clock);
    repeat (4000) if (k < 9) begin
      @(negedge clock);
      v = s ? rtOut : stOut;
      if (v && !p && k == 0) t0 = cyc;
      if (v && !p) k++;
      if (k == 9) n = cyc - t0;
      p = v;
    end
  endtask
  task automatic put(input logic h, input logic [7:0] d);
    logic t;
    @(posedge clock);
    ifData <= d;
    ifHdr <= h;
    ifValid <= 1'b1;
    t = 1'b0;
    while (!t) begin
      @(negedge clock);
      t = ifReady;
      @(posedge clock);
      if (t) ifValid <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(`REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk(`REG_SYNTH_WORD, 32'hFFFFFFFF, 32'h07D00000);
    wStrb <= 4'h1;
    wr(`REG_SYNTH_WORD, 32'hFFFFFFAB);
    wStrb <= 4'hF;
    rdchk(`REG_SYNTH_WORD, 32'hFFFFFFFF, 32'h07D000AB);
    rdchk(`REG_DIV_CTRL, 32'h0001FFFF, 32'h00004000);
    rdchk(`REG_CLK_SEL, 32'h3FF, 32'h0);
    rdchk(`REG_PKT_SIZE, 32'h7FF, 32'h400);
    rd(8'h18, rv, rr);
    check({30'h0, rr}, 32'h2);
    wr(8'h18, 32'h0);
    check({30'h0, bResp}, 32'h2);
    // a reference far off the nominal count never locks
    repeat (16) @(posedge clock) refIn <= !refIn;
    rdchk(`REG_STATUS, 32'h1, 32'h0);
  endtask
  task automatic t_bounds();
    logic [7:0] ra [0:5] = '{8'h08, 8'h08, 8'h08, 8'h04, 8'h04, 8'h04};
    logic [31:0] va [0:5] = '{32'h3, 32'h4002, 32'h4000, 32'h7F, 32'h5DC00001, 32'h80};
    logic [31:0] ea [0:5] = '{32'h2, 32'h2, 32'h0, 32'h4, 32'h4, 32'h0};
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], va[i]);
      rdchk(`REG_STATUS, i < 3 ? 32'h2 : 32'h4, ea[i]);
    end
  endtask
  task automatic t_rates();
    wr(`REG_SYNTH_WORD, 32'h1F400000);
    wr(`REG_CTRL, 32'h0);
    per(0, c);
    near(c, 243, 245);
    wr(`REG_CTRL, 32'h4);
    wr(`REG_DIV_CTRL, 32'h00010002);
    wr(`REG_CLK_SEL, 32'h140);
    repeat (64) @(posedge clock);
    rdchk(`REG_STATUS, 32'h3FF00, 32'h14000);
    per(0, c);
    near(c, 243, 245);
    per(1, c);
    near(c, 487, 490);
    wr(`REG_CTRL, 32'h5);
    repeat (64) @(posedge clock);
    rdchk(`REG_STATUS, 32'h3FF00, 32'h3FF00);
    per(0, c);
    check(c, 0);
    wr(`REG_CTRL, 32'h3);
    per(0, c);
    near(c, 487, 490);
  endtask
  task automatic t_packets();
    int k, n, bad;
    logic lst;
    logic [7:0] f;
    wr(`REG_PKT_SIZE, 32'h5);
    rdchk(`REG_PKT_SIZE, 32'h7FF, 32'h5);
    wr(`REG_CTRL, 32'h1);
    k = 0;
    n = 0;
    bad = 0;
    lst = 1'b0;
    repeat (30000) if (!lst) begin
      @(negedge clock);
      if (pValid && pFirst) k++;
      if (pValid && pFirst) f = pData;
      if (pValid && k == 2) n++;
      if (pValid && k == 2) bad += int'(pData !== f);
      if (pValid && k == 2) lst = pLast;
    end
    check(n, 32);
    check(bad, 0);
  endtask
  task automatic t_iface();
    int b;
    logic [15:0] s;
    logic pr, go;
    b = 0;
    go = 1'b0;
    pr = 1'b0;
    s = 16'h0;
    fork
      begin
        put(1'b1, 8'h00);
        put(1'b0, 8'h5A);
        put(1'b1, 8'h00);
        put(1'b0, 8'h81);
      end
      repeat (4000) if (b < 16) begin
        @(negedge clock);
        if (pr && !rtOut && (go || !rxOut)) begin
          go = 1'b1;
          s = {rxOut, s[15:1]};
          b++;
        end
        pr = rtOut;
      end
    join
    check({16'h0, s}, 32'h815A);
  endtask
  initial begin
    failures = 0;
    tests_run = 0;
    cyc = 0;
    srst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady, ifValid, ifHdr, refIn} = 8'h0;
    wStrb = 4'hF;
    {awAddr, arAddr, ifData} = 24'h0;
    wData = 32'h0;
    txByte = 8'h3C;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_bounds();
    t_rates();
    t_packets();
    t_iface();
    final_report();
  end
endmodule // tb_serial_port_clock_select
`default_nettype wire
